// [dv/dwspi_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module dwspi_properties #(
  parameter int NVW_CYCLES = 40
) (
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, low
  input wire logic sck, // Serial clock
  input wire logic cs_n, // Select, low
  input wire logic si, // Data to device
  input wire logic so, // Data from device
  input wire logic so_oe, // Device drives so
  input wire logic hold_n, // Pause, low
  input wire logic wp_n, // Protect, low
  input wire logic nvw_busy // Slot write running
);
  logic [15:0] busy_cnt_q;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Length of the running slot write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_cnt_q <= 16'h0000;
    end else begin
      busy_cnt_q <= nvw_busy ? busy_cnt_q + 16'h0001 : 16'h0000;
    end
  end
  // Link inputs pass a two-flop sync, so releases get a few cycles of slack
  chk_cs_release: assert property (cs_n [*5] |-> !so_oe)
    else $error("so driven while deselected");
  chk_hold_release: assert property (!hold_n [*5] |-> !so_oe)
    else $error("so driven while paused");
  chk_so_on_fall: assert property ($changed(so) && so_oe && $past(so_oe)
    |-> !sck && !$past(sck, 2))
    else $error("so changed outside sck low phase");
  chk_oe_cause: assert property ($rose(so_oe) |-> !cs_n && hold_n)
    else $error("so enabled without select");
  chk_sck_idle: assert property (cs_n [*2] |-> $stable(sck))
    else $error("sck moved while deselected");
  chk_sck_setup: assert property ($fell(cs_n) |=> $stable(sck) [*6])
    else $error("sck moved right after select");
  chk_hold_edge: assert property ($changed(hold_n) |-> !$past(sck))
    else $error("pause changed while sck high");
  chk_hold_freeze: assert property (!hold_n && !$past(hold_n) |-> $stable(sck))
    else $error("sck moved while paused");
  chk_nvw_cause: assert property ($rose(nvw_busy) |-> cs_n && $past(cs_n, 2))
    else $error("slot write started without deselect");
  chk_nvw_span: assert property ($fell(nvw_busy) |-> busy_cnt_q == 16'(NVW_CYCLES))
    else $error("slot write length wrong");
  cov_slot_write: cover property ($fell(nvw_busy));
  cov_pause: cover property ($fell(hold_n));
  cov_read_out: cover property ($rose(so_oe));
  cov_mode3: cover property ($fell(cs_n) ##1 sck);
endmodule
`default_nettype wire

// [dv/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "dwspi_params.svh"
module testbench;
  import dwspi_pkg::*;
  localparam int NVW = 16;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic addr_pin_low, addr_pin_high, nvw_busy;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] rx;
  logic [1:0] dv;
  dwspi_wiper_t wiper_pos0, wiper_pos1;
  dwspi_wiper_t wip [2];
  dwspi_wiper_t slt [2][4];
  int errors, num_checks;
  dwspi_if link_if();
  dwspi_device #(.NVW_CYCLES(NVW)) dwspi_device_i (.pclk(pclk), .presetn(presetn),
    .link(link_if.dev), .addr_pin_low(addr_pin_low), .addr_pin_high(addr_pin_high),
    .wiper_pos0(wiper_pos0), .wiper_pos1(wiper_pos1), .nvw_busy(nvw_busy));
  dwspi_master dwspi_master_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(link_if.mst));
  dwspi_properties #(.NVW_CYCLES(NVW)) dwspi_properties_i (.pclk(pclk), .presetn(presetn),
    .sck(link_if.sck), .cs_n(link_if.cs_n), .si(link_if.si), .so(link_if.so),
    .so_oe(link_if.so_oe), .hold_n(link_if.hold_n), .wp_n(link_if.wp_n), .nvw_busy(nvw_busy));
  // Free-running system clock
  initial begin
    pclk = 1'h0;
    forever #12.5 pclk = ~pclk;
  end
  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic cmp_data(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmp_flag(input string what, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic give_up(input string what);
    errors++;
    $display("MISMATCH %s expected done seen timeout", what);
    stop_test();
  endtask
  // One APB transfer; entered and left just after a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 40);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (pready !== 1'h1) give_up("apb ready");
    @(posedge pclk);
  endtask
  task automatic pins(input logic [1:0] v);
    apb(1'h1, `DWSPI_REG_PINS, {30'h0, v});
  endtask
  task automatic go(input logic [7:0] i, input logic [7:0] d, input logic m3);
    apb(1'h1, `DWSPI_REG_CMD, {14'h0, m3, 1'h1, i, d});
  endtask
  // Poll until the frame and any slot write are over
  task automatic wait_done();
    int n;
    n = 0;
    do begin
      apb(1'h0, `DWSPI_REG_STAT, 32'h0);
      n++;
    end while (rd[0] !== 1'h0 && n < 200);
    if (rd[0] !== 1'h0) give_up("frame end");
    rx = rd[23:16];
    n = 0;
    while (nvw_busy !== 1'h0 && n < 200) begin
      @(posedge pclk);
      n++;
    end
    if (nvw_busy !== 1'h0) give_up("slot write end");
  endtask
  // Reference model; a released output line reads as all ones
  function automatic logic [7:0] model_op(input logic [7:0] i, input logic [7:0] d,
      input logic wp);
    logic [7:0] r;
    r = 8'hff;
    if (i[`DWSPI_DEV_MSB:`DWSPI_DEV_LSB] == {addr_pin_high, addr_pin_low}) begin
      case (i[`DWSPI_OP_MSB:`DWSPI_OP_LSB])
        `DWSPI_OP_RD_WIPER: r = {2'h0, wip[i[2]]};
        `DWSPI_OP_WR_WIPER: wip[i[2]] = d[5:0];
        `DWSPI_OP_RD_SLOT: r = {2'h0, slt[i[2]][i[1:0]]};
        `DWSPI_OP_WR_SLOT: if (wp) slt[i[2]][i[1:0]] = d[5:0];
        `DWSPI_OP_SLOT_TO_WIPER: wip[i[2]] = slt[i[2]][i[1:0]];
        `DWSPI_OP_WIPER_TO_SLOT: if (wp) slt[i[2]][i[1:0]] = wip[i[2]];
        default: r = 8'hff;
      endcase
    end
    return r;
  endfunction
  task automatic xfer(input logic [7:0] i, input logic [7:0] d, input logic m3, input logic wp);
    logic [7:0] e;
    e = model_op(i, d, wp);
    go(i, d, m3);
    wait_done();
    cmp_data("read byte", {24'h0, e}, {24'h0, rx});
    cmp_data("wiper 0", {26'h0, wip[0]}, {26'h0, wiper_pos0});
    cmp_data("wiper 1", {26'h0, wip[1]}, {26'h0, wiper_pos1});
  endtask
  // Main sequence
  initial begin
    int k;
    logic [7:0] i8;
    logic [7:0] e;
    void'($urandom(32'hfb5b9242));
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {addr_pin_high, addr_pin_low} = 2'($urandom);
    foreach (slt[p, s]) slt[p][s] = `DWSPI_SLOT_RESET;
    foreach (wip[p]) wip[p] = slt[p][0];
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    repeat (4) @(posedge pclk);
    cmp_data("reset wiper 0", {26'h0, wip[0]}, {26'h0, wiper_pos0});
    cmp_data("reset wiper 1", {26'h0, wip[1]}, {26'h0, wiper_pos1});
    apb(1'h0, `DWSPI_REG_PINS, 32'h0);
    cmp_data("pins reset", {30'h0, `DWSPI_PINS_RESET}, rd);
    apb(1'h0, 12'h00c, 32'h0);
    cmp_flag("unmapped error", 1'h1, err);
    cmp_data("unmapped data", 32'h0, rd);
    dv = {addr_pin_high, addr_pin_low};
    // Every opcode in turn, random fields and mode, occasional foreign address
    for (k = 0; k < 18; k++) begin
      i8 = {3'(k % 6), dv, 3'($urandom)};
      if ($urandom % 5 == 0) i8[4:3] = ~dv;
      xfer(i8, 8'($urandom), 1'($urandom), 1'h1);
    end
    // All four device addresses; only the matching one answers
    for (k = 0; k < 4; k++) begin
      {addr_pin_high, addr_pin_low} <= 2'(k);
      @(posedge pclk);
      xfer({`DWSPI_OP_WR_WIPER, 2'(k), 3'(k)}, 8'($urandom), 1'(k), 1'h1);
      xfer({`DWSPI_OP_WR_WIPER, 2'(k + 1), 3'(k)}, 8'($urandom), 1'h0, 1'h1);
      xfer({`DWSPI_OP_RD_WIPER, 2'(k + 2), 3'(k)}, 8'h00, 1'h1, 1'h1);
    end
    dv = {addr_pin_high, addr_pin_low};
    // Protect low: slots frozen, wipers still writable
    pins(2'h0);
    xfer({`DWSPI_OP_WR_SLOT, dv, 3'h5}, 8'h2a, 1'h0, 1'h0);
    xfer({`DWSPI_OP_WIPER_TO_SLOT, dv, 3'h6}, 8'h00, 1'h1, 1'h0);
    xfer({`DWSPI_OP_WR_WIPER, dv, 3'h4}, 8'h3f, 1'h1, 1'h0);
    xfer({`DWSPI_OP_RD_SLOT, dv, 3'h5}, 8'h00, 1'h0, 1'h0);
    pins(2'h1);
    // Protect falls mid-frame: the slot write is dropped
    go({`DWSPI_OP_WR_SLOT, dv, 3'h2}, 8'h15, 1'h0);
    repeat (100) @(posedge pclk);
    pins(2'h0);
    wait_done();
    pins(2'h1);
    xfer({`DWSPI_OP_RD_SLOT, dv, 3'h2}, 8'h00, 1'h0, 1'h1);
    // Protect falls after the slot write began: it still lands
    i8 = {`DWSPI_OP_WR_SLOT, dv, 3'h2};
    e = model_op(i8, 8'h15, 1'h1);
    go(i8, 8'h15, 1'h1);
    k = 0;
    while (nvw_busy !== 1'h1 && k < 800) begin
      @(posedge pclk);
      k++;
    end
    if (nvw_busy !== 1'h1) give_up("slot write start");
    pins(2'h0);
    wait_done();
    pins(2'h1);
    xfer({`DWSPI_OP_RD_SLOT, dv, 3'h2}, 8'h00, 1'h0, 1'h1);
    // Pause in the data byte of a read, then resume
    i8 = {`DWSPI_OP_RD_WIPER, dv, 3'h4};
    e = model_op(i8, 8'h00, 1'h1);
    go(i8, 8'h00, 1'($urandom));
    repeat (150) @(posedge pclk);
    pins(2'h3);
    k = 0;
    while (link_if.hold_n !== 1'h0 && k < 100) begin
      @(posedge pclk);
      k++;
    end
    if (link_if.hold_n !== 1'h0) give_up("pause entry");
    repeat (60) @(posedge pclk);
    apb(1'h0, `DWSPI_REG_STAT, 32'h0);
    cmp_flag("paused", 1'h1, rd[1]);
    cmp_flag("so enable in pause", 1'h0, link_if.so_oe);
    pins(2'h1);
    wait_done();
    cmp_data("paused read", {24'h0, e}, {24'h0, rx});
    stop_test();
  end
endmodule
`default_nettype wire

// [hdl/dwspi_device.sv]
// Decided for this implementation: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "dwspi_params.svh"

module dwspi_device #(
  parameter int NVW_CYCLES = `DWSPI_NVW_CYCLES
) (
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, low
  dwspi_if.dev link, // Serial link
  input wire logic addr_pin_low, // Device address bit 0
  input wire logic addr_pin_high, // Device address bit 1
  output dwspi_pkg::dwspi_wiper_t wiper_pos0, // Tap of pot 0
  output dwspi_pkg::dwspi_wiper_t wiper_pos1, // Tap of pot 1
  output logic nvw_busy // Slot write running
);
  import dwspi_pkg::*;

  logic [6:0] pin_raw;
  logic [6:0] sync1_q;
  logic [6:0] sync2_q;
  logic sck_s, cs_s, si_s, hold_s, wp_s;
  logic [1:0] addr_s;
  logic sck_prev_q, cs_prev_q, wp_prev_q;
  logic rise_ok, fall_ok, cs_fall, cs_rise, wp_fall, byte_done;
  logic paused_q;
  dwspi_dev_state_e state_q;
  logic [2:0] bitcnt_q;
  logic [7:0] shift_q;
  logic [7:0] in_byte;
  logic [7:0] instr_q;
  logic [7:0] out_q;
  logic so_q, so_oe_q;
  dwspi_wiper_t wiper_q [2];
  dwspi_wiper_t slot_q [2][4];
  logic pend_q, abort_q, pend_pot_q;
  logic [1:0] pend_idx_q;
  dwspi_wiper_t pend_data_q;
  logic nvw_busy_q;
  logic [15:0] nvw_cnt_q;
  logic addr_match;
  dwspi_op_t in_op, cur_op;
  logic in_pot;
  logic [1:0] in_idx;

  function automatic dwspi_op_t op_of(input logic [7:0] b);
    op_of = b[`DWSPI_OP_MSB:`DWSPI_OP_LSB];
  endfunction

  function automatic logic is_read(input dwspi_op_t op);
    is_read = (op == `DWSPI_OP_RD_WIPER) || (op == `DWSPI_OP_RD_SLOT);
  endfunction

  function automatic logic has_data(input dwspi_op_t op);
    has_data = is_read(op) || (op == `DWSPI_OP_WR_WIPER) || (op == `DWSPI_OP_WR_SLOT);
  endfunction

  // Every pin, serial clock included, crosses two flops first
  assign pin_raw = {addr_pin_high, addr_pin_low, link.wp_n, link.hold_n, link.si,
                    link.cs_n, link.sck};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= `DWSPI_SYNC_RESET;
      sync2_q <= `DWSPI_SYNC_RESET;
    end else begin
      sync1_q <= pin_raw;
      sync2_q <= sync1_q;
    end
  end

  assign sck_s = sync2_q[0];
  assign cs_s = sync2_q[1];
  assign si_s = sync2_q[2];
  assign hold_s = sync2_q[3];
  assign wp_s = sync2_q[4];
  assign addr_s = sync2_q[6:5];

  // Edge history of the synchronised pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
      wp_prev_q <= 1'b1;
    end else begin
      sck_prev_q <= sck_s;
      cs_prev_q <= cs_s;
      wp_prev_q <= wp_s;
    end
  end

  // Clock edges count only while selected and not paused
  assign rise_ok = sck_s & ~sck_prev_q & ~cs_s & ~paused_q;
  assign fall_ok = ~sck_s & sck_prev_q & ~cs_s & ~paused_q;
  assign cs_fall = ~cs_s & cs_prev_q;
  assign cs_rise = cs_s & ~cs_prev_q;
  assign wp_fall = ~wp_s & wp_prev_q;
  assign byte_done = rise_ok && (bitcnt_q == 3'h7);
  assign in_byte = {shift_q[6:0], si_s};
  assign in_op = op_of(in_byte);
  assign in_pot = in_byte[`DWSPI_POT_BIT];
  assign in_idx = in_byte[`DWSPI_SLOT_MSB:`DWSPI_SLOT_LSB];
  assign cur_op = op_of(instr_q);
  assign addr_match = (in_byte[`DWSPI_DEV_MSB:`DWSPI_DEV_LSB] == addr_s);

  // Pause is taken only with the clock low and left with the clock low or on deselect
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      paused_q <= 1'b0;
    end else if (cs_s) begin
      paused_q <= 1'b0;
    end else if (!paused_q && !hold_s && !sck_s) begin
      paused_q <= 1'b1;
    end else if (paused_q && hold_s && !sck_s) begin
      paused_q <= 1'b0;
    end
  end

  // Sequence state; bit count and shifter freeze during a pause
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= DEV_RECALL;
      bitcnt_q <= 3'h0;
      shift_q <= 8'h00;
      instr_q <= 8'h00;
    end else if (state_q == DEV_RECALL) begin
      state_q <= DEV_IDLE;
    end else if (cs_s) begin
      state_q <= DEV_IDLE;
      bitcnt_q <= 3'h0;
    end else if (cs_fall) begin
      // A running slot write keeps the part deaf to a new sequence
      state_q <= nvw_busy_q ? DEV_IGNORE : DEV_INSTR;
      bitcnt_q <= 3'h0;
    end else if (rise_ok) begin
      shift_q <= in_byte;
      bitcnt_q <= bitcnt_q + 3'h1;
      case (state_q)
        DEV_INSTR: begin
          if (byte_done) begin
            instr_q <= in_byte;
            if (!addr_match) begin
              state_q <= DEV_IGNORE;
            end else if (has_data(in_op)) begin
              state_q <= DEV_DATA;
            end else begin
              state_q <= DEV_DONE;
            end
          end
        end
        DEV_DATA: begin
          if (byte_done) begin
            state_q <= DEV_DONE;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Wiper positions: recall, copy from slot, direct write
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wiper_q[0] <= `DWSPI_SLOT_RESET;
      wiper_q[1] <= `DWSPI_SLOT_RESET;
    end else if (state_q == DEV_RECALL) begin
      wiper_q[0] <= slot_q[0][0];
      wiper_q[1] <= slot_q[1][0];
    end else if (!cs_s && !cs_fall && byte_done) begin
      if (state_q == DEV_INSTR && addr_match && in_op == `DWSPI_OP_SLOT_TO_WIPER) begin
        wiper_q[in_pot] <= slot_q[in_pot][in_idx];
      end else if (state_q == DEV_DATA && cur_op == `DWSPI_OP_WR_WIPER) begin
        // Wiper writes stay open even with protect low
        wiper_q[instr_q[`DWSPI_POT_BIT]] <= in_byte[5:0];
      end
    end
  end

  // Read data: loaded after the instruction, moved out on falls
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_q <= 8'h00;
      so_q <= 1'b0;
      so_oe_q <= 1'b0;
    end else begin
      so_oe_q <= (state_q == DEV_DATA) && is_read(cur_op) && !cs_s && !paused_q;
      if (state_q == DEV_INSTR && byte_done && !cs_fall) begin
        out_q <= {2'h0, (in_op == `DWSPI_OP_RD_WIPER) ? wiper_q[in_pot]
                                                      : slot_q[in_pot][in_idx]};
      end else if (state_q == DEV_DATA && fall_ok && is_read(cur_op)) begin
        so_q <= out_q[7];
        out_q <= {out_q[6:0], 1'b0};
      end
    end
  end

  // Pending slot write, armed by the sequence, launched by deselect
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q <= 1'b0;
      abort_q <= 1'b0;
      pend_pot_q <= 1'b0;
      pend_idx_q <= 2'h0;
      pend_data_q <= `DWSPI_SLOT_RESET;
    end else if (cs_fall) begin
      pend_q <= 1'b0;
      abort_q <= 1'b0;
    end else if (cs_rise) begin
      pend_q <= 1'b0;
    end else if (!cs_s && wp_fall) begin
      pend_q <= 1'b0;
      abort_q <= 1'b1;
    end else if (byte_done && wp_s && !abort_q) begin
      // Protect low never arms a slot write
      if (state_q == DEV_INSTR && addr_match && in_op == `DWSPI_OP_WIPER_TO_SLOT) begin
        pend_q <= 1'b1;
        pend_pot_q <= in_pot;
        pend_idx_q <= in_idx;
        pend_data_q <= wiper_q[in_pot];
      end else if (state_q == DEV_DATA && cur_op == `DWSPI_OP_WR_SLOT) begin
        pend_q <= 1'b1;
        pend_pot_q <= instr_q[`DWSPI_POT_BIT];
        pend_idx_q <= instr_q[`DWSPI_SLOT_MSB:`DWSPI_SLOT_LSB];
        pend_data_q <= in_byte[5:0];
      end
    end
  end

  // Internal write cycle; once started nothing stops it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nvw_busy_q <= 1'b0;
      nvw_cnt_q <= 16'h0000;
    end else if (nvw_busy_q) begin
      nvw_cnt_q <= nvw_cnt_q - 16'h0001;
      if (nvw_cnt_q == 16'h0001) begin
        nvw_busy_q <= 1'b0;
      end
    end else if (cs_rise && pend_q && wp_s && !abort_q) begin
      nvw_busy_q <= 1'b1;
      nvw_cnt_q <= 16'(NVW_CYCLES);
    end
  end

  // Saved slots keep their data; only the end of a write cycle changes them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int p = 0; p < 2; p++) begin
        for (int s = 0; s < 4; s++) begin
          slot_q[p][s] <= `DWSPI_SLOT_RESET;
        end
      end
    end else if (nvw_busy_q && nvw_cnt_q == 16'h0001) begin
      slot_q[pend_pot_q][pend_idx_q] <= pend_data_q;
    end
  end

  assign link.so = so_q;
  assign link.so_oe = so_oe_q;
  assign wiper_pos0 = wiper_q[0];
  assign wiper_pos1 = wiper_q[1];
  assign nvw_busy = nvw_busy_q;
endmodule
`default_nettype wire

// [hdl/dwspi_master.sv]
`timescale 1ns/1ps
`default_nettype none
`include "dwspi_params.svh"

module dwspi_master #(
  parameter int HALF_DIV = `DWSPI_HALF_DIV
) (
  input wire logic pclk, // System clock
  input wire logic presetn, // Async reset, low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  dwspi_if.mst link // Serial link
);
  import dwspi_pkg::*;

  dwspi_mst_state_e state_q;
  logic [31:0] prdata_q;
  logic pready_q, pslverr_q;
  logic [7:0] instr_q, data_q;
  logic mode3_q, wp_q, pause_q;
  logic sck_q, cs_n_q, si_q, hold_n_q;
  logic [15:0] tx_q, rx_q;
  logic [4:0] bit_q;
  logic [15:0] div_q;
  logic tick, wr_take, go;
  logic so_sync1_q, so_sync2_q;
  logic [1:0] sel;

  function automatic logic [1:0] reg_sel(input logic [11:0] a);
    case (a)
      `DWSPI_REG_CMD: reg_sel = 2'h0;
      `DWSPI_REG_PINS: reg_sel = 2'h1;
      `DWSPI_REG_STAT: reg_sel = 2'h2;
      default: reg_sel = 2'h3;
    endcase
  endfunction

  assign sel = reg_sel(paddr);
  assign wr_take = psel & penable & pready_q & pwrite;
  assign go = wr_take && sel == 2'h0 && pwdata[`DWSPI_CMD_GO_BIT] && state_q == MST_IDLE;
  assign tick = (div_q == 16'(HALF_DIV - 1));

  // One wait state on every access keeps read data registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else if (psel && penable && !pready_q) begin
      pready_q <= 1'b1;
      pslverr_q <= (sel == 2'h3);
      case (sel)
        2'h0: prdata_q <= {14'h0, mode3_q, 1'b0, instr_q, data_q};
        2'h1: prdata_q <= {30'h0, pause_q, wp_q};
        2'h2: prdata_q <= {rx_q, 14'h0, ~hold_n_q, state_q != MST_IDLE};
        default: prdata_q <= 32'h00000000;
      endcase
    end else begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  // Software registers; a start while busy is dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      instr_q <= 8'h00;
      data_q <= 8'h00;
      mode3_q <= 1'b0;
      wp_q <= 1'(`DWSPI_PINS_RESET & 2'h1);
      pause_q <= 1'b0;
    end else if (wr_take) begin
      if (sel == 2'h0 && state_q == MST_IDLE) begin
        data_q <= pwdata[7:0];
        instr_q <= pwdata[15:8];
        mode3_q <= pwdata[`DWSPI_CMD_MODE3_BIT];
      end else if (sel == 2'h1) begin
        wp_q <= pwdata[`DWSPI_PINS_WP_BIT];
        pause_q <= pwdata[`DWSPI_PINS_PAUSE_BIT];
      end
    end
  end

  // Returned serial data crosses two flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      so_sync1_q <= 1'b1;
      so_sync2_q <= 1'b1;
    end else begin
      so_sync1_q <= link.so_line;
      so_sync2_q <= so_sync1_q;
    end
  end

  // Half-period divider, held at zero while paused
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 16'h0000;
    end else if (state_q == MST_IDLE || !hold_n_q || tick) begin
      div_q <= 16'h0000;
    end else begin
      div_q <= div_q + 16'h0001;
    end
  end

  // Pause line moves only while the clock is low, never on the edge
  // that raises it; otherwise pause and rise coincide and the line sticks low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_n_q <= 1'b1;
    end else if (state_q == MST_SHIFT && !sck_q && !tick) begin
      hold_n_q <= ~pause_q;
    end else if (state_q != MST_SHIFT) begin
      hold_n_q <= 1'b1;
    end
  end

  // Frame sequencer: instruction byte then data byte, msb first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= MST_IDLE;
      sck_q <= 1'b0;
      cs_n_q <= 1'b1;
      si_q <= 1'b0;
      tx_q <= 16'h0000;
      rx_q <= 16'h0000;
      bit_q <= 5'h00;
    end else begin
      case (state_q)
        MST_IDLE: begin
          sck_q <= mode3_q;
          if (go) begin
            sck_q <= pwdata[`DWSPI_CMD_MODE3_BIT];
            tx_q <= pwdata[15:0];
            si_q <= pwdata[15];
            cs_n_q <= 1'b0;
            bit_q <= 5'h00;
            state_q <= MST_SETUP;
          end
        end
        MST_SETUP: begin
          if (tick) begin
            sck_q <= 1'b0;
            state_q <= MST_SHIFT;
          end
        end
        MST_SHIFT: begin
          if (tick && hold_n_q) begin
            if (!sck_q) begin
              sck_q <= 1'b1;
              rx_q <= {rx_q[14:0], so_sync2_q};
              bit_q <= bit_q + 5'h01;
            end else if (bit_q == 5'h10) begin
              sck_q <= mode3_q;
              state_q <= MST_FINISH;
            end else begin
              sck_q <= 1'b0;
              tx_q <= {tx_q[14:0], 1'b0};
              si_q <= tx_q[14];
            end
          end
        end
        MST_FINISH: begin
          if (tick) begin
            cs_n_q <= 1'b1;
            state_q <= MST_GAP;
          end
        end
        MST_GAP: begin
          if (tick) begin
            state_q <= MST_IDLE;
          end
        end
        default: state_q <= MST_IDLE;
      endcase
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign link.sck = sck_q;
  assign link.cs_n = cs_n_q;
  assign link.si = si_q;
  assign link.hold_n = hold_n_q;
  assign link.wp_n = wp_q;
endmodule
`default_nettype wire

// [shared/dwspi_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface dwspi_if;
  logic sck;
  logic cs_n;
  logic si;
  logic so;
  logic so_oe;
  logic hold_n;
  logic wp_n;
  logic so_line;
  // Released line is pulled high
  assign so_line = so_oe ? so : 1'b1;
  modport dev (input sck, cs_n, si, hold_n, wp_n, output so, so_oe);
  modport mst (output sck, cs_n, si, hold_n, wp_n, input so_line);
endinterface
`default_nettype wire

// [shared/dwspi_params.svh]
`ifndef DWSPI_PARAMS_SVH
`define DWSPI_PARAMS_SVH

// Instruction byte layout: opcode, device address, pot select, slot index
`define DWSPI_OP_MSB 7
`define DWSPI_OP_LSB 5
`define DWSPI_DEV_MSB 4
`define DWSPI_DEV_LSB 3
`define DWSPI_POT_BIT 2
`define DWSPI_SLOT_MSB 1
`define DWSPI_SLOT_LSB 0

// Opcodes
`define DWSPI_OP_RD_WIPER 3'h0
`define DWSPI_OP_WR_WIPER 3'h1
`define DWSPI_OP_RD_SLOT 3'h2
`define DWSPI_OP_WR_SLOT 3'h3
`define DWSPI_OP_SLOT_TO_WIPER 3'h4
`define DWSPI_OP_WIPER_TO_SLOT 3'h5

// Reset values
`define DWSPI_SLOT_RESET 6'h00
`define DWSPI_SYNC_RESET 7'h1a

// Timing
`define DWSPI_CLK_PERIOD_NS 25
`define DWSPI_NVW_TIME_NS 1000
`define DWSPI_NVW_CYCLES ((`DWSPI_NVW_TIME_NS + `DWSPI_CLK_PERIOD_NS - 1) / `DWSPI_CLK_PERIOD_NS)
`define DWSPI_HALF_DIV 8

// Controller register offsets and fields
`define DWSPI_REG_CMD 12'h000
`define DWSPI_REG_PINS 12'h004
`define DWSPI_REG_STAT 12'h008
`define DWSPI_CMD_GO_BIT 16
`define DWSPI_CMD_MODE3_BIT 17
`define DWSPI_PINS_WP_BIT 0
`define DWSPI_PINS_PAUSE_BIT 1
`define DWSPI_PINS_RESET 2'h1

`endif

// [shared/dwspi_pkg.sv]
`default_nettype none
package dwspi_pkg;
  typedef logic [5:0] dwspi_wiper_t;
  typedef logic [2:0] dwspi_op_t;
  typedef enum logic [2:0] {
    DEV_RECALL, DEV_IDLE, DEV_INSTR, DEV_DATA, DEV_DONE, DEV_IGNORE
  } dwspi_dev_state_e;
  typedef enum logic [2:0] {
    MST_IDLE, MST_SETUP, MST_SHIFT, MST_FINISH, MST_GAP
  } dwspi_mst_state_e;
endpackage
`default_nettype wire
